// >>> hw/dac_cfg_pkg.sv
package dac_cfg_pkg;
   // ***********************************************
   // Widths and counts
   // ***********************************************
   localparam int unsigned DATA_W     = 14;
   localparam int unsigned CHANNELS   = 8;
   localparam int unsigned GAIN_SHIFT = 14;
   // ***********************************************
   // Register byte offsets
   // ***********************************************
   localparam logic [11:0] CFG_OFFSET  = 12'h000;
   localparam logic [11:0] CHAN_OFFSET = 12'h040;
   // ***********************************************
   // Configuration field positions
   // ***********************************************
   localparam int unsigned READBACK_SEL_BIT = 13;
   localparam int unsigned SYNC_LOAD_BIT    = 12;
   localparam int unsigned SOFT_RESET_BIT   = 11;
   localparam int unsigned PD_A_BIT         = 10;
   localparam int unsigned PD_B_BIT         = 9;
   localparam int unsigned CAL_EN_BIT       = 8;
   localparam int unsigned BUSY_BIT         = 7;
   localparam int unsigned SPAN_A_BIT       = 6;
   localparam int unsigned SPAN_B_BIT       = 5;
   // ***********************************************
   // Reset values and correction constants
   // ***********************************************
   localparam logic [13:0] CFG_RESET  = 14'h2000;
   localparam logic [13:0] CHAN_RESET = 14'h0000;
   localparam logic [14:0] GAIN_UNITY = 15'h2000;
   localparam logic [13:0] CODE_MAX   = 14'h3FFF;
   // ***********************************************
   // Bus responses
   // ***********************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dac_cfg_pkg

// >>> hw/dac_config_control_register.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// How it works
// - Channel read gives input value if select is 0, channel data if 1.
// - Under correction, input keeps raw word, channel data keeps corrected one.
// - Sync load with pin high waits for write and correction, loads written channels.
// - Any load reloads only latches of channels written since last load.
// - Sync load bit clears itself once the latch update is done.
// - Sync load bit ignored while the load pin is low.
// - Correction off, sync load updates latches right after the write.
// - Soft reset bit resets all like hardware reset, then reads 0.
// - Group A powerdown bit powers down channels 0 to 3.
// - Group B powerdown bit powers down channels 4 to 7.
// - Calibration on: word corrected by gain and zero, then latched.
// - Calibration off: word passes unchanged to channel data, then latch.
// - Busy flag reads 1 while any channel awaits correction.
// - Busy flag is 0 whenever calibration is disabled.
// - Group A span bit picks six or four times reference A.
// - Group A span change reloads group A offset trim.
// - Group B span bit picks six or four times reference B.
// - Group B span change reloads group B offset trim.
// - Lowest five config bits ignore writes and read zero.
// - Config reads 2000h after reset.
module dac_config_control_register #(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   output      logic [1:0]             s_axi_bresp,
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   output      logic [31:0]            s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   async_latch_load_n,
   input  wire logic [8*14-1:0]        gain_codes,
   input  wire logic [8*14-1:0]        zero_codes,
   output      logic [8*14-1:0]        latch_values,
   output      logic                   group_a_powerdown,
   output      logic                   group_b_powerdown,
   output      logic                   group_a_span,
   output      logic                   group_b_span,
   output      logic                   offset_reload_a,
   output      logic                   offset_reload_b,
   output      logic                   calibration_enable,
   output      logic                   engine_busy_flag
);
   localparam int unsigned N = dac_cfg_pkg::CHANNELS;
   localparam int unsigned W = dac_cfg_pkg::DATA_W;

   logic          soft_rst;
   logic          rst_all;
   logic          readback_sel;
   logic          sync_pending;
   logic [N-1:0]  pending;
   logic [N-1:0]  accessed;
   logic [W-1:0]  input_data [N];
   logic [W-1:0]  chan_data  [N];
   logic          wr_hs;
   logic          wr_cfg;
   logic          wr_ch;
   logic [2:0]    wr_idx;
   logic [W-1:0]  wr_word;
   logic [W-1:0]  cfg_view;
   logic          sync_set;
   logic          do_load;
   logic          fire;
   logic [2:0]    fire_idx;
   logic [W-1:0]  corrected;
   logic          rd_cfg;
   logic          rd_ch;
   logic [2:0]    rd_idx;

   // Byte lanes merged into the old value, narrow data in low bits
   function automatic logic [13:0] merge(input logic [13:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[13:8] : old[13:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   // Gain 0..3FFFh spans 0.5..1.5, zero is twos complement, result saturates
   function automatic logic [13:0] correct(input logic [13:0] x, input logic [13:0] g,
                                           input logic [13:0] z);
      logic [29:0] prod;
      logic signed [16:0] sum;
      prod = 30'(x) * 30'(dac_cfg_pkg::GAIN_UNITY + 15'(g));
      sum  = signed'({2'b00, prod[28:14]}) + 17'(signed'(z));
      if (sum < 0) begin
         correct = 14'h0000;
      end else if (sum > 17'(dac_cfg_pkg::CODE_MAX)) begin
         correct = dac_cfg_pkg::CODE_MAX;
      end else begin
         correct = sum[13:0];
      end
   endfunction : correct

   // ***********************************************
   // Reset
   // ***********************************************
   // Soft reset is a one-cycle pulse folded into the common reset
   assign rst_all = !aresetn || soft_rst;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr_cfg && wr_word[dac_cfg_pkg::SOFT_RESET_BIT] && !soft_rst;
      end
   end

   // ***********************************************
   // Write channel
   // ***********************************************
   // Address and data taken together; no response buffering needed
   assign wr_hs         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_hs;
   assign s_axi_wready  = wr_hs;
   assign wr_cfg = wr_hs && s_axi_awaddr[11:0] == dac_cfg_pkg::CFG_OFFSET;
   assign wr_ch  = wr_hs && s_axi_awaddr[11:5] == dac_cfg_pkg::CHAN_OFFSET[11:5]
                   && s_axi_awaddr[1:0] == 2'b00;
   assign wr_idx = s_axi_awaddr[4:2];
   assign wr_word = merge(wr_cfg ? cfg_view : input_data[wr_idx], s_axi_wdata, s_axi_wstrb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dac_cfg_pkg::RESP_OKAY;
      end else if (wr_hs) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_cfg || wr_ch) ? dac_cfg_pkg::RESP_OKAY : dac_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***********************************************
   // Configuration fields
   // ***********************************************
   // pin low blocks the sync load request
   assign sync_set = wr_cfg && wr_word[dac_cfg_pkg::SYNC_LOAD_BIT] && async_latch_load_n;

   always_ff @(posedge aclk) begin
      if (rst_all) begin
         readback_sel       <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::READBACK_SEL_BIT];
         group_a_powerdown  <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::PD_A_BIT];
         group_b_powerdown  <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::PD_B_BIT];
         calibration_enable <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::CAL_EN_BIT];
         group_a_span       <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::SPAN_A_BIT];
         group_b_span       <= dac_cfg_pkg::CFG_RESET[dac_cfg_pkg::SPAN_B_BIT];
      end else if (wr_cfg && !wr_word[dac_cfg_pkg::SOFT_RESET_BIT]) begin
         readback_sel       <= wr_word[dac_cfg_pkg::READBACK_SEL_BIT];
         group_a_powerdown  <= wr_word[dac_cfg_pkg::PD_A_BIT];
         group_b_powerdown  <= wr_word[dac_cfg_pkg::PD_B_BIT];
         calibration_enable <= wr_word[dac_cfg_pkg::CAL_EN_BIT];
         group_a_span       <= wr_word[dac_cfg_pkg::SPAN_A_BIT];
         group_b_span       <= wr_word[dac_cfg_pkg::SPAN_B_BIT];
      end
   end

   // reload pulse whenever span A changes, soft reset included
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offset_reload_a <= 1'b0;
         offset_reload_b <= 1'b0;
      end else if (soft_rst) begin
         offset_reload_a <= group_a_span;
         offset_reload_b <= group_b_span;
      end else begin
         offset_reload_a <= wr_cfg && !wr_word[dac_cfg_pkg::SOFT_RESET_BIT]
                            && wr_word[dac_cfg_pkg::SPAN_A_BIT] != group_a_span;
         // reload pulse on span B change
         offset_reload_b <= wr_cfg && !wr_word[dac_cfg_pkg::SOFT_RESET_BIT]
                            && wr_word[dac_cfg_pkg::SPAN_B_BIT] != group_b_span;
      end
   end

   // held until correction is done, set wins over clear
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         sync_pending <= 1'b0;
      end else if (sync_set) begin
         sync_pending <= 1'b1;
      end else if (do_load) begin
         sync_pending <= 1'b0;
      end
   end

   // low bits read zero; busy only from engine state
   always_comb begin
      cfg_view = '0;
      cfg_view[dac_cfg_pkg::READBACK_SEL_BIT] = readback_sel;
      cfg_view[dac_cfg_pkg::SYNC_LOAD_BIT]    = sync_pending;
      cfg_view[dac_cfg_pkg::PD_A_BIT]         = group_a_powerdown;
      cfg_view[dac_cfg_pkg::PD_B_BIT]         = group_b_powerdown;
      cfg_view[dac_cfg_pkg::CAL_EN_BIT]       = calibration_enable;
      cfg_view[dac_cfg_pkg::BUSY_BIT]         = engine_busy_flag;
      cfg_view[dac_cfg_pkg::SPAN_A_BIT]       = group_a_span;
      cfg_view[dac_cfg_pkg::SPAN_B_BIT]       = group_b_span;
   end

   // ***********************************************
   // Correction engine
   // ***********************************************
   // One channel per cycle, lowest index first
   always_comb begin
      fire_idx = 3'd0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pending[i]) begin
            fire_idx = 3'(i);
         end
      end
   end
   assign fire = calibration_enable && (pending != '0);
   assign corrected = correct(input_data[fire_idx], gain_codes[14*fire_idx +: 14],
                              zero_codes[14*fire_idx +: 14]);
   // busy while work remains; forced low without calibration
   assign engine_busy_flag = fire;

   always_ff @(posedge aclk) begin
      if (rst_all || !calibration_enable) begin
         pending <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr_ch && wr_idx == 3'(i)) begin
               pending[i] <= 1'b1;
            end else if (fire && fire_idx == 3'(i)) begin
               pending[i] <= 1'b0;
            end
         end
      end
   end

   // ***********************************************
   // Channel storage and latches
   // ***********************************************
   // pin low is a transparent load of written channels
   assign do_load = !async_latch_load_n || (sync_pending && !fire);

   always_ff @(posedge aclk) begin
      if (rst_all) begin
         for (int i = 0; i < N; i++) begin
            input_data[i] <= dac_cfg_pkg::CHAN_RESET;
            chan_data[i]  <= dac_cfg_pkg::CHAN_RESET;
         end
         accessed <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr_ch && wr_idx == 3'(i)) begin
               // raw word always kept in input stage
               input_data[i] <= wr_word;
            end
            if (wr_ch && wr_idx == 3'(i) && !calibration_enable) begin
               chan_data[i] <= wr_word;
               accessed[i]  <= 1'b1;
            end else if (fire && fire_idx == 3'(i)) begin
               chan_data[i] <= corrected;
               accessed[i]  <= 1'b1;
            end else if (do_load) begin
               accessed[i]  <= 1'b0;
            end
         end
      end
   end

   // with correction off this lands the cycle after the write
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         latch_values <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (do_load && accessed[i]) begin
               latch_values[14*i +: 14] <= chan_data[i];
            end
         end
      end
   end

   // ***********************************************
   // Read channel
   // ***********************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_cfg = s_axi_araddr[11:0] == dac_cfg_pkg::CFG_OFFSET;
   assign rd_ch  = s_axi_araddr[11:5] == dac_cfg_pkg::CHAN_OFFSET[11:5]
                   && s_axi_araddr[1:0] == 2'b00;
   assign rd_idx = s_axi_araddr[4:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= dac_cfg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= (rd_cfg || rd_ch) ? dac_cfg_pkg::RESP_OKAY : dac_cfg_pkg::RESP_SLVERR;
         if (rd_cfg) begin
            s_axi_rdata <= {18'h00000, cfg_view};
         end else if (rd_ch) begin
            s_axi_rdata <= {18'h00000, readback_sel ? chan_data[rd_idx] : input_data[rd_idx]};
         end else begin
            s_axi_rdata <= '0;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_busy_cal_off: assert property (!calibration_enable |-> !engine_busy_flag)
      else $error("busy flag set with calibration off");
   chk_busy_pending: assert property (wr_ch && calibration_enable && !soft_rst |=> engine_busy_flag)
      else $error("busy flag low with work pending");
   chk_sync_clears: assert property (sync_pending && !fire && !sync_set |=> !sync_pending)
      else $error("sync load bit did not clear");
   chk_pin_ignores: assert property (!async_latch_load_n && !sync_set |=> !sync_pending)
      else $error("sync load kept while pin low");
   chk_untouched_latch: assert property (do_load && !accessed[0] && !rst_all
                                         |=> $stable(latch_values[13:0]))
      else $error("unaccessed latch reloaded");
   chk_low_bits_zero: assert property (cfg_view[4:0] == 5'h00)
      else $error("reserved config bits not zero");
   chk_soft_reset_val: assert property (soft_rst |=> cfg_view == dac_cfg_pkg::CFG_RESET)
      else $error("soft reset did not restore config");
   chk_pass_through: assert property (wr_ch && wr_idx == 3'd0 && !calibration_enable
                                      && !soft_rst |=> chan_data[0] == $past(wr_word))
      else $error("uncorrected word not passed through");
   chk_cal_result: assert property (fire && fire_idx == 3'd3 && !soft_rst
                                    |=> chan_data[3] == $past(corrected))
      else $error("corrected word not stored");
   chk_span_reload: assert property (wr_cfg && !wr_word[dac_cfg_pkg::SOFT_RESET_BIT]
                                     && !soft_rst && wr_word[dac_cfg_pkg::SPAN_A_BIT] != group_a_span
                                     |=> offset_reload_a && group_a_span != $past(group_a_span))
      else $error("span A change without offset reload");
   chk_readback_sel: assert property (s_axi_arvalid && s_axi_arready && rd_ch && rd_idx == 3'd3
                                      && !readback_sel
                                      |=> s_axi_rdata[13:0] == $past(input_data[3]))
      else $error("channel read gave wrong stage");
   chk_sync_loads: assert property (sync_pending && !fire && accessed[1] && !rst_all
                                    |=> latch_values[27:14] == $past(chan_data[1]))
      else $error("sync load did not update latch");
endmodule : dac_config_control_register

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic        aclk,
   output      logic [11:0] s_axi_awaddr,
   output      logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output      logic [31:0] s_axi_wdata,
   output      logic [3:0]  s_axi_wstrb,
   output      logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   output      logic        s_axi_bready,
   output      logic [11:0] s_axi_araddr,
   output      logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   output      logic        s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // ***********************************************
   // Bus cycles
   // ***********************************************
   // finish write first
   task automatic write(input logic [11:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         // Released lines flip so stale values cannot pass
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : write
   task automatic read(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr  <= ~a;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : read
endmodule : host_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic          aclk, aresetn, async_latch_load_n;
   logic [11:0]   s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic          s_axi_rvalid, s_axi_rready;
   logic [111:0]  gain_codes, zero_codes, latch_values;
   logic          group_a_powerdown, group_b_powerdown, group_a_span, group_b_span;
   logic          offset_reload_a, offset_reload_b, calibration_enable, engine_busy_flag;
   int            err_total, comparisons, cycles, rel_a, rel_b;
   logic          busy_seen;
   logic [1:0]    exp_b[$];
   logic [33:0]   exp_r[$];
   logic [13:0]   lat[8];
   logic [13:0]   dat[8];
   logic [13:0]   val;
   logic [13:0]   corr;
   localparam logic [11:0] CFG = dac_cfg_pkg::CFG_OFFSET;

   dac_config_control_register #(.ADDR_W(12)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .async_latch_load_n, .gain_codes, .zero_codes, .latch_values,
      .group_a_powerdown, .group_b_powerdown, .group_a_span, .group_b_span,
      .offset_reload_a, .offset_reload_b, .calibration_enable, .engine_busy_flag);
   host_model i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

   initial aclk = 1'b0;
   always #2.5 aclk = ~aclk;
   // ***********************************************
   // Checking
   // ***********************************************
   task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: bus %h, want %h", $time, got, exp);
      end
   endtask : cmp_bus
   task automatic cmp_port(input logic [111:0] got, input logic [111:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: port %h, want %h", $time, got, exp);
      end
   endtask : cmp_port
   task automatic end_of_test;
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   always @(posedge aclk) begin
      cycles++;
      if (cycles > 20000) begin
         err_total++;
         end_of_test();
      end
      if (s_axi_bvalid && s_axi_bready)
         cmp_bus({s_axi_bresp, 32'h0}, {exp_b.pop_front(), 32'h0});
      if (s_axi_rvalid && s_axi_rready)
         cmp_bus({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
      if (aresetn && !calibration_enable)
         cmp_port(112'(engine_busy_flag), 112'h0);
      if (engine_busy_flag === 1'b1)
         busy_seen = 1'b1;
      if (offset_reload_a === 1'b1)
         rel_a++;
      if (offset_reload_b === 1'b1)
         rel_b++;
   end
   // ***********************************************
   // Stimulus helpers
   // ***********************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r = dac_cfg_pkg::RESP_OKAY);
      exp_b.push_back(r);
      i_host.write(a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r = dac_cfg_pkg::RESP_OKAY);
      exp_r.push_back({r, d});
      i_host.read(a);
   endtask : rd
   function automatic logic [11:0] ch(input int n);
      return dac_cfg_pkg::CHAN_OFFSET + 12'(4 * n);
   endfunction : ch
   function automatic logic [111:0] pk();
      logic [111:0] v;
      for (int n = 0; n < 8; n++)
         v[14*n +: 14] = lat[n];
      return v;
   endfunction : pk
   // Signed sum is wide enough that saturation never wraps
   function automatic logic [13:0] fix(input logic [13:0] x, g, z);
      logic [28:0]        p;
      logic signed [16:0] s;
      p = 29'(x) * (29'h2000 + 29'(g));
      s = $signed({2'h0, p[28:14]}) + $signed({{3{z[13]}}, z});
      if (s < 0) return 14'h0;
      if (s > 17'sh3FFF) return dac_cfg_pkg::CODE_MAX;
      return s[13:0];
   endfunction : fix
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      void'($urandom(32'h6390));
      {aresetn, err_total, comparisons, cycles, rel_a, rel_b, busy_seen} = '0;
      async_latch_load_n = 1'b1;
      for (int n = 0; n < 8; n++) begin
         gain_codes[14*n +: 14] = 14'($urandom);
         zero_codes[14*n +: 14] = 14'($urandom);
         lat[n] = 14'h0;
         dat[n] = 14'($urandom);
      end
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CFG, 32'h2000);
      wr(CFG, 32'h27FF);
      rd(CFG, 32'h2760);
      cmp_port(112'({group_a_powerdown, group_b_powerdown, group_a_span, group_b_span,
                     calibration_enable}), 112'h1F);
      wr(CFG, 32'h2000);
      for (int n = 0; n < 8; n++) begin
         wr(ch(n), {18'h0, dat[n]});
         rd(ch(n), {18'h0, dat[n]});
      end
      cmp_port(latch_values, pk());
      wr(CFG, 32'h3000);
      repeat (4) @(posedge aclk);
      lat = dat;
      cmp_port(latch_values, pk());
      rd(CFG, 32'h2000);
      @(posedge aclk) async_latch_load_n <= 1'b0;
      val = 14'($urandom);
      wr(ch(1), {18'h0, val});
      repeat (3) @(posedge aclk);
      lat[1] = val;
      cmp_port(latch_values, pk());
      wr(CFG, 32'h3000);
      rd(CFG, 32'h2000);
      @(posedge aclk) async_latch_load_n <= 1'b1;
      wr(12'h060, 32'h3FFF, dac_cfg_pkg::RESP_SLVERR);
      rd(12'h060, 32'h0, dac_cfg_pkg::RESP_SLVERR);
      rd(CFG, 32'h2000);
      wr(CFG, 32'h0100);
      val = 14'($urandom);
      wr(ch(3), {18'h0, val});
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 50 && engine_busy_flag !== 1'b0; i++) @(posedge aclk);
      rd(ch(3), {18'h0, val});
      corr = fix(val, gain_codes[42 +: 14], zero_codes[42 +: 14]);
      wr(CFG, 32'h2100);
      rd(ch(3), {18'h0, corr});
      rd(CFG, 32'h2100);
      cmp_port(112'(busy_seen), 112'h1);
      wr(CFG, 32'h3100);
      repeat (4) @(posedge aclk);
      lat[3] = corr;
      cmp_port(latch_values, pk());
      wr(CFG, 32'h2660);
      cmp_port(112'({group_a_powerdown, group_b_powerdown, group_a_span, group_b_span,
                     calibration_enable}), 112'h1E);
      wr(CFG, 32'h0800);
      repeat (3) @(posedge aclk);
      rd(CFG, 32'h2000);
      rd(ch(3), 32'h0);
      cmp_port(latch_values, 112'h0);
      cmp_port(112'({group_a_powerdown, group_b_powerdown, group_a_span, group_b_span,
                     calibration_enable}), 112'h0);
      cmp_port(112'({32'(rel_a), 32'(rel_b)}), {48'h0, 32'h4, 32'h4});
      end_of_test();
   end
endmodule : testbench
